// File: include/lstu_consts.vh
// Constants for the load, store and transfer unit: opcodes, sub-operations, bus map.
`ifndef LSTU_CONSTS_VH
`define LSTU_CONSTS_VH

// Word and field widths.
`define LSTU_WORD_W      24
`define LSTU_IDX_W       15
`define LSTU_CHAR_W      6
`define LSTU_CADDR_W     17

// Opcodes, six bits (octal 20..27, 40..47, 53, 54).
`define LSTU_OP_LD_ACC   6'h10
`define LSTU_OP_LD_EXT   6'h11
`define LSTU_OP_LD_ACH   6'h12
`define LSTU_OP_LD_ECH   6'h13
`define LSTU_OP_LD_INV   6'h14
`define LSTU_OP_LD_DBL   6'h15
`define LSTU_OP_LD_DINV  6'h16
`define LSTU_OP_LD_MASK  6'h17
`define LSTU_OP_ST_ACC   6'h20
`define LSTU_OP_ST_EXT   6'h21
`define LSTU_OP_ST_ACH   6'h22
`define LSTU_OP_ST_ECH   6'h23
`define LSTU_OP_ST_WPTR  6'h24
`define LSTU_OP_ST_DBL   6'h25
`define LSTU_OP_ST_CPTR  6'h26
`define LSTU_OP_ST_IDX   6'h27
`define LSTU_OP_XFER     6'h2b
`define LSTU_OP_LD_IDX   6'h2c

// Sub-operations of the shared transfer opcode.
`define LSTU_SUB_IDX_ACC 3'h0
`define LSTU_SUB_FL_EXT  3'h1
`define LSTU_SUB_FL_ACC  3'h2
`define LSTU_SUB_FL_IDX  3'h3
`define LSTU_SUB_SUM_AE  3'h4
`define LSTU_SUB_SUM_AI  3'h5
`define LSTU_SUB_SUM_IA  3'h6

// APB register byte offsets.
`define LSTU_REG_ACC     8'h00
`define LSTU_REG_EXT     8'h04
`define LSTU_REG_IDX1    8'h08
`define LSTU_REG_IDX2    8'h0c
`define LSTU_REG_IDX3    8'h10
`define LSTU_REG_STATUS  8'h14
`define LSTU_REG_CTRL    8'h18

// Reset values.
`define LSTU_CTRL_RST    1'h1

`endif

// File: hdl/lstu_load_store_unit.v
// Load, store and inter-register transfer datapath with an APB register port.
//
// Summary of operation
// - Word load puts word at M into accumulator.
// - Word load puts word at M into extension.
// - Word loads allow indirect and indexed addressing.
// - Accumulator char load clears, loads char, index 1.
// - Extension char load clears, loads char, index 2.
// - Character loads and stores never go indirect.
// - Inverted load puts ones-complement into accumulator.
// - Double load: M to accumulator, M+1 to extension.
// - Inverted double load complements both loaded words.
// - Masked load ANDs extension with word at M.
// - Index load takes low 15 bits, unindexed address.
// - Index indirect uses mode, address; original designator.
// - Word stores write register, source unchanged.
// - Accumulator char store, index 2, others kept.
// - Extension char store, index 1, others kept.
// - Word-pointer store replaces low 15 bits only.
// - Double store: accumulator to M, extension M+1.
// - Char-pointer store replaces low 17 bits only.
// - Index store low 15 bits; designator zero stores zero.
// - Opcode 53 index/accumulator moves, no sign extension.
// - Register file of 64 entries, direction bit d.
// - Sum of accumulator and extension into accumulator.
// - Index gets low bits of sign-extended sum.
//
// The APB register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "lstu_consts.vh"

module lstu_load_store_unit #(
  parameter FILE_DEPTH = 64
) (
  input  wire        clk_sys_in,
  input  wire        rst_in,
  // Instruction issue.
  input  wire        start_in,
  input  wire [5:0]  op_in,
  input  wire        indirect_in,
  input  wire [1:0]  index_sel_in,
  input  wire [16:0] addr_in,
  input  wire        dir_in,
  input  wire [2:0]  sub_op_in,
  output reg         busy_out,
  output reg         done_out,
  // Core storage port.
  output reg         mem_req_out,
  output reg         mem_we_out,
  output reg  [14:0] mem_addr_out,
  output reg  [23:0] mem_wdata_out,
  input  wire [23:0] mem_rdata_in,
  input  wire        mem_ack_in,
  // APB slave.
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [7:0]  paddr_in,
  input  wire [31:0] pwdata_in,
  output reg  [31:0] prdata_out,
  output reg         pready_out,
  output reg         pslverr_out
);

  localparam [5:0] S_IDLE = 6'h01;
  localparam [5:0] S_IND  = 6'h02;
  localparam [5:0] S_RD   = 6'h04;
  localparam [5:0] S_RD2  = 6'h08;
  localparam [5:0] S_WR   = 6'h10;
  localparam [5:0] S_WR2  = 6'h20;

  reg [5:0]  state_ff;
  reg [23:0] acc_ff;
  reg [23:0] ext_ff;
  reg [14:0] idx_ff [1:3];
  reg [23:0] file_ff [0:FILE_DEPTH-1];
  reg [5:0]  op_ff;
  reg [1:0]  sel_ff;
  reg [1:0]  cpos_ff;
  reg        enable_ff;
  reg        file_we;
  reg [5:0]  file_addr;
  reg [23:0] file_wdata;

  // Index register read, designator zero reads as zero.
  function [14:0] idx_get;
    input [1:0] sel;
    begin
      idx_get = (sel == 2'h0) ? 15'h0000 : idx_ff[sel];
    end
  endfunction

  // Character position 0 is the most significant six bits of the word.
  function [5:0] char_get;
    input [23:0] word;
    input [1:0]  pos;
    begin
      case (pos)
        2'h0:    char_get = word[23:18];
        2'h1:    char_get = word[17:12];
        2'h2:    char_get = word[11:6];
        default: char_get = word[5:0];
      endcase
    end
  endfunction

  // Replaces one character and keeps the other three.
  function [23:0] char_put;
    input [23:0] word;
    input [1:0]  pos;
    input [5:0]  ch;
    begin
      case (pos)
        2'h0:    char_put = {ch, word[17:0]};
        2'h1:    char_put = {word[23:18], ch, word[11:0]};
        2'h2:    char_put = {word[23:12], ch, word[5:0]};
        default: char_put = {word[23:6], ch};
      endcase
    end
  endfunction

  // Sign-extends an index value to a full word.
  function [23:0] sext;
    input [14:0] v;
    begin
      sext = {{9{v[14]}}, v};
    end
  endfunction

  wire        is_idx_op = (op_in == `LSTU_OP_LD_IDX) || (op_in == `LSTU_OP_ST_IDX);
  wire        is_chr_op = (op_in == `LSTU_OP_LD_ACH) || (op_in == `LSTU_OP_LD_ECH) ||
                          (op_in == `LSTU_OP_ST_ACH) || (op_in == `LSTU_OP_ST_ECH);
  // Load-accumulator and store-extension characters use index 1, the others index 2.
  wire        chr_uses1 = (op_in == `LSTU_OP_LD_ACH) || (op_in == `LSTU_OP_ST_ECH);
  wire [14:0] chr_ofs   = (index_sel_in != 2'h1) ? 15'h0000 :
                          (chr_uses1 ? idx_ff[1] : idx_ff[2]);
  wire [16:0] chr_addr  = addr_in + {2'h0, chr_ofs};
  wire [14:0] word_ea   = addr_in[14:0] + (is_idx_op ? 15'h0000 : idx_get(index_sel_in));
  wire        apb_hit   = psel_in && penable_in && !pready_out;
  wire [23:0] ia_sum    = acc_ff + sext(idx_get(index_sel_in));
  wire [23:0] ae_sum    = acc_ff + ext_ff;
  wire [23:0] rdata     = mem_rdata_in;
  wire [23:0] file_rd   = file_ff[addr_in[5:0]];

  // Starts the data access once the effective address is final.
  task go_op;
    input [5:0]  op;
    input [14:0] ea;
    begin
      mem_addr_out <= ea;
      mem_req_out  <= 1'b1;
      case (op)
        `LSTU_OP_ST_ACC, `LSTU_OP_ST_DBL: begin
          mem_we_out    <= 1'b1;
          mem_wdata_out <= acc_ff;
          state_ff      <= S_WR;
        end
        `LSTU_OP_ST_EXT: begin
          mem_we_out    <= 1'b1;
          mem_wdata_out <= ext_ff;
          state_ff      <= S_WR;
        end
        default: begin
          mem_we_out <= 1'b0;
          state_ff   <= S_RD;
        end
      endcase
    end
  endtask

  // Register file write port; the data array has no reset.
  always @(posedge clk_sys_in) begin
    if (file_we) begin
      file_ff[file_addr] <= file_wdata;
    end
  end

  // Register file write request from the transfer opcode.
  always @* begin
    file_we    = 1'b0;
    file_addr  = addr_in[5:0];
    file_wdata = acc_ff;
    if ((state_ff == S_IDLE) && start_in && enable_ff && (op_in == `LSTU_OP_XFER) && dir_in) begin
      case (sub_op_in)
        `LSTU_SUB_FL_EXT: begin
          file_we    = 1'b1;
          file_wdata = ext_ff;
        end
        `LSTU_SUB_FL_ACC: begin
          file_we = 1'b1;
        end
        `LSTU_SUB_FL_IDX: begin
          file_we    = 1'b1;
          file_wdata = {9'h000, idx_get(index_sel_in)};
        end
        default: begin
          file_we = 1'b0;
        end
      endcase
    end
  end

  // Sequencer, working registers and APB slave.
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      state_ff      <= S_IDLE;
      acc_ff        <= 24'h000000;
      ext_ff        <= 24'h000000;
      idx_ff[1]     <= 15'h0000;
      idx_ff[2]     <= 15'h0000;
      idx_ff[3]     <= 15'h0000;
      op_ff         <= 6'h00;
      sel_ff        <= 2'h0;
      cpos_ff       <= 2'h0;
      enable_ff     <= `LSTU_CTRL_RST;
      busy_out      <= 1'b0;
      done_out      <= 1'b0;
      mem_req_out   <= 1'b0;
      mem_we_out    <= 1'b0;
      mem_addr_out  <= 15'h0000;
      mem_wdata_out <= 24'h000000;
      prdata_out    <= 32'h00000000;
      pready_out    <= 1'b0;
      pslverr_out   <= 1'b0;
    end else begin
      done_out    <= 1'b0;
      pready_out  <= apb_hit;
      pslverr_out <= 1'b0;
      // APB access: answered on the second access cycle; writes only land while idle.
      if (apb_hit) begin
        prdata_out <= 32'h00000000;
        case (paddr_in)
          `LSTU_REG_ACC:    prdata_out <= {8'h00, acc_ff};
          `LSTU_REG_EXT:    prdata_out <= {8'h00, ext_ff};
          `LSTU_REG_IDX1:   prdata_out <= {17'h00000, idx_ff[1]};
          `LSTU_REG_IDX2:   prdata_out <= {17'h00000, idx_ff[2]};
          `LSTU_REG_IDX3:   prdata_out <= {17'h00000, idx_ff[3]};
          `LSTU_REG_STATUS: prdata_out <= {26'h0000000, state_ff};
          `LSTU_REG_CTRL:   prdata_out <= {31'h00000000, enable_ff};
          default:          pslverr_out <= 1'b1;
        endcase
        if (pwrite_in && (state_ff == S_IDLE) && !start_in) begin
          case (paddr_in)
            `LSTU_REG_ACC:  acc_ff <= pwdata_in[23:0];
            `LSTU_REG_EXT:  ext_ff <= pwdata_in[23:0];
            `LSTU_REG_IDX1: idx_ff[1] <= pwdata_in[14:0];
            `LSTU_REG_IDX2: idx_ff[2] <= pwdata_in[14:0];
            `LSTU_REG_IDX3: idx_ff[3] <= pwdata_in[14:0];
            `LSTU_REG_CTRL: enable_ff <= pwdata_in[0];
            default:        enable_ff <= enable_ff;
          endcase
        end
      end
      case (state_ff)
        S_IDLE: begin
          if (start_in && enable_ff) begin
            op_ff  <= op_in;
            sel_ff <= index_sel_in;
            if (op_in == `LSTU_OP_XFER) begin
              done_out <= 1'b1;
              case (sub_op_in)
                `LSTU_SUB_IDX_ACC: begin
                  if (!dir_in) begin
                    acc_ff <= {9'h000, idx_get(index_sel_in)};
                  end else if (index_sel_in != 2'h0) begin
                    idx_ff[index_sel_in] <= acc_ff[14:0];
                  end
                end
                `LSTU_SUB_FL_EXT: if (!dir_in) ext_ff <= file_rd;
                `LSTU_SUB_FL_ACC: if (!dir_in) acc_ff <= file_rd;
                `LSTU_SUB_FL_IDX: begin
                  if (!dir_in && (index_sel_in != 2'h0)) begin
                    idx_ff[index_sel_in] <= file_rd[14:0];
                  end
                end
                `LSTU_SUB_SUM_AE: acc_ff <= ae_sum;
                `LSTU_SUB_SUM_AI: acc_ff <= ia_sum;
                `LSTU_SUB_SUM_IA: begin
                  if (index_sel_in != 2'h0) begin
                    idx_ff[index_sel_in] <= ia_sum[14:0];
                  end
                end
                default: acc_ff <= acc_ff;
              endcase
            end else if (is_chr_op) begin
              // Character operations ignore the indirect flag.
              busy_out     <= 1'b1;
              cpos_ff      <= chr_addr[1:0];
              mem_addr_out <= chr_addr[16:2];
              mem_req_out  <= 1'b1;
              mem_we_out   <= 1'b0;
              state_ff     <= S_RD;
            end else begin
              busy_out <= 1'b1;
              if (indirect_in) begin
                mem_addr_out <= word_ea;
                mem_req_out  <= 1'b1;
                mem_we_out   <= 1'b0;
                state_ff     <= S_IND;
              end else begin
                go_op(op_in, word_ea);
              end
            end
          end
        end
        S_IND: begin
          if (mem_ack_in) begin
            // Indirect word: bit 17 chains, 16:15 index, 14:0 address.
            if (rdata[17]) begin
              mem_addr_out <= rdata[14:0] +
                ((op_ff == `LSTU_OP_LD_IDX || op_ff == `LSTU_OP_ST_IDX) ?
                 15'h0000 : idx_get(rdata[16:15]));
            end else begin
              go_op(op_ff, rdata[14:0] +
                ((op_ff == `LSTU_OP_LD_IDX || op_ff == `LSTU_OP_ST_IDX) ?
                 15'h0000 : idx_get(rdata[16:15])));
            end
          end
        end
        S_RD: begin
          if (mem_ack_in) begin
            mem_req_out <= 1'b0;
            state_ff    <= S_IDLE;
            busy_out    <= 1'b0;
            done_out    <= 1'b1;
            case (op_ff)
              `LSTU_OP_LD_ACC:  acc_ff <= rdata;
              `LSTU_OP_LD_EXT:  ext_ff <= rdata;
              `LSTU_OP_LD_INV:  acc_ff <= ~rdata;
              `LSTU_OP_LD_MASK: acc_ff <= ext_ff & rdata;
              `LSTU_OP_LD_ACH:  acc_ff <= {18'h00000, char_get(rdata, cpos_ff)};
              `LSTU_OP_LD_ECH:  ext_ff <= {18'h00000, char_get(rdata, cpos_ff)};
              `LSTU_OP_LD_IDX: begin
                if (sel_ff != 2'h0) idx_ff[sel_ff] <= rdata[14:0];
              end
              `LSTU_OP_LD_DBL, `LSTU_OP_LD_DINV: begin
                acc_ff       <= (op_ff == `LSTU_OP_LD_DINV) ? ~rdata : rdata;
                mem_addr_out <= mem_addr_out + 15'h0001;
                mem_req_out  <= 1'b1;
                state_ff     <= S_RD2;
                busy_out     <= 1'b1;
                done_out     <= 1'b0;
              end
              default: begin
                // Read half of a partial store; the write follows.
                mem_req_out <= 1'b1;
                mem_we_out  <= 1'b1;
                state_ff    <= S_WR;
                busy_out    <= 1'b1;
                done_out    <= 1'b0;
                case (op_ff)
                  `LSTU_OP_ST_WPTR: mem_wdata_out <= {rdata[23:15], acc_ff[14:0]};
                  `LSTU_OP_ST_CPTR: mem_wdata_out <= {rdata[23:17], acc_ff[16:0]};
                  `LSTU_OP_ST_IDX:  mem_wdata_out <= {rdata[23:15], idx_get(sel_ff)};
                  `LSTU_OP_ST_ACH:  mem_wdata_out <= char_put(rdata, cpos_ff, acc_ff[5:0]);
                  default:          mem_wdata_out <= char_put(rdata, cpos_ff, ext_ff[5:0]);
                endcase
              end
            endcase
          end
        end
        S_RD2: begin
          if (mem_ack_in) begin
            ext_ff      <= (op_ff == `LSTU_OP_LD_DINV) ? ~rdata : rdata;
            mem_req_out <= 1'b0;
            state_ff    <= S_IDLE;
            busy_out    <= 1'b0;
            done_out    <= 1'b1;
          end
        end
        S_WR: begin
          if (mem_ack_in) begin
            if (op_ff == `LSTU_OP_ST_DBL) begin
              mem_addr_out  <= mem_addr_out + 15'h0001;
              mem_wdata_out <= ext_ff;
              state_ff      <= S_WR2;
            end else begin
              mem_req_out <= 1'b0;
              mem_we_out  <= 1'b0;
              state_ff    <= S_IDLE;
              busy_out    <= 1'b0;
              done_out    <= 1'b1;
            end
          end
        end
        S_WR2: begin
          if (mem_ack_in) begin
            mem_req_out <= 1'b0;
            mem_we_out  <= 1'b0;
            state_ff    <= S_IDLE;
            busy_out    <= 1'b0;
            done_out    <= 1'b1;
          end
        end
        default: begin
          state_ff    <= S_IDLE;
          mem_req_out <= 1'b0;
          busy_out    <= 1'b0;
        end
      endcase
    end
  end

endmodule // lstu_load_store_unit

// File: testbench/lstu_mem_model.sv
// Core storage model that answers the unit's storage port after a chosen latency.
`timescale 1ns/1ps
module lstu_mem_model (
  input  wire        clk_sys_in,
  input  wire        req_in,
  input  wire        we_in,
  input  wire [14:0] addr_in,
  input  wire [23:0] wdata_in,
  input  wire [1:0]  lat_in,
  output reg  [23:0] rdata_out = 24'h0,
  output reg         ack_out = 1'b0
);
  reg [23:0] mem [0:32767];
  reg [1:0]  cnt_ff = 2'h0;

  // One ack pulse per access; read data is scrambled every cycle outside the ack.
  always @(posedge clk_sys_in) begin
    ack_out <= 1'b0;
    rdata_out <= ~rdata_out;
    if (req_in && !ack_out) begin
      cnt_ff <= cnt_ff + 2'h1;
      if (cnt_ff >= lat_in) begin
        ack_out <= 1'b1;
        cnt_ff <= 2'h0;
        rdata_out <= mem[addr_in];
        if (we_in)
          mem[addr_in] <= wdata_in;
      end
    end
  end
endmodule // lstu_mem_model

// File: testbench/lstu_load_store_unit_asserts.sv
// Concurrent checks on the issue, storage and register-bus ports of the unit.
`timescale 1ns/1ps
module lstu_asserts (
  input wire        clk_sys_in,
  input wire        rst_in,
  input wire        busy_out,
  input wire        done_out,
  input wire        mem_req_out,
  input wire        mem_we_out,
  input wire [14:0] mem_addr_out,
  input wire [23:0] mem_wdata_out,
  input wire        mem_ack_in,
  input wire        psel_in,
  input wire        penable_in,
  input wire [7:0]  paddr_in,
  input wire [31:0] prdata_out,
  input wire        pready_out,
  input wire        pslverr_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);

  // Completion, storage handshake and register-bus timing.
  property p_done_pulse; done_out |=> !done_out; endproperty
  property p_req_busy; mem_req_out |-> busy_out; endproperty
  property p_req_hold;
    mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_addr_out)
      && $stable(mem_we_out) && $stable(mem_wdata_out);
  endproperty
  property p_last_ack; mem_req_out && mem_ack_in ##1 !mem_req_out |-> done_out; endproperty
  property p_finish; $rose(busy_out) |-> ##[0:60] done_out; endproperty
  property p_apb_ready; psel_in && penable_in && !pready_out |=> pready_out; endproperty
  property p_ready_pulse; pready_out |=> !pready_out; endproperty
  property p_bad_addr;
    psel_in && penable_in && !pready_out && paddr_in > 8'h18
      |=> pslverr_out && prdata_out == 32'h0;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("done held over one cycle");
  a_req_busy: assert property (p_req_busy)
    else $error("storage request while idle");
  a_req_hold: assert property (p_req_hold)
    else $error("storage request changed before ack");
  a_last_ack: assert property (p_last_ack)
    else $error("no done after final ack");
  a_finish: assert property (p_finish)
    else $error("instruction did not finish");
  a_apb_ready: assert property (p_apb_ready)
    else $error("register access not answered");
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready held over one cycle");
  a_bad_addr: assert property (p_bad_addr)
    else $error("unmapped access not refused");
  c_done: cover property (done_out);
  c_err: cover property (pready_out && pslverr_out);
  c_wr: cover property (mem_ack_in && mem_we_out);
endmodule // lstu_asserts

bind lstu_load_store_unit lstu_asserts chk_u (.*);

// File: testbench/tb_load_store_transfer_unit.sv
// Self-checking bench for the load, store and transfer unit.
`timescale 1ns/1ps
`include "lstu_consts.vh"
module tb_load_store_transfer_unit;
  reg         clk_sys_in = 1'b0, rst_in = 1'b1, start_in = 1'b0, indirect_in = 1'b0;
  reg         dir_in = 1'b0, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0, err;
  reg  [5:0]  op_in = 6'h0;
  reg  [1:0]  index_sel_in = 2'h0, lat = 2'h0;
  reg  [16:0] addr_in = 17'h0;
  reg  [2:0]  sub_op_in = 3'h0;
  reg  [7:0]  paddr_in = 8'h0;
  reg  [31:0] pwdata_in = 32'h0, rd;
  wire [31:0] prdata_out;
  wire [23:0] mem_wdata_out, mem_rdata_in;
  wire [14:0] mem_addr_out;
  wire        busy_out, done_out, mem_req_out, mem_we_out, mem_ack_in;
  wire        pready_out, pslverr_out;
  integer     n_fail = 0, compares = 0, cyc = 0;

  lstu_load_store_unit dut_u (.*);
  lstu_mem_model mm_u (.clk_sys_in(clk_sys_in), .req_in(mem_req_out), .we_in(mem_we_out),
    .addr_in(mem_addr_out), .wdata_in(mem_wdata_out), .lat_in(lat),
    .rdata_out(mem_rdata_in), .ack_out(mem_ack_in));

  // Clock of 10 ns period.
  initial begin
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  // Cycle ceiling that cuts a hang short.
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail = n_fail + 1;
      report_and_stop;
    end
  end

  task report_and_stop;
    begin
      $display("compares %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        n_fail = n_fail + 1;
      end
    end
  endtask

  // One register-bus transfer: setup, access until ready, then release.
  task apb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk_sys_in);
      psel_in <= 1'b1;
      pwrite_in <= w;
      paddr_in <= a;
      pwdata_in <= d;
      @(posedge clk_sys_in);
      penable_in <= 1'b1;
      @(posedge clk_sys_in);
      while (pready_out !== 1'b1)
        @(posedge clk_sys_in);
      rd = prdata_out;
      err = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
    end
  endtask

  task rchk(input string nm, input [7:0] a, input [31:0] exp);
    begin
      apb(1'b0, a, 32'h0);
      chk(nm, rd, exp);
    end
  endtask

  // Issues one instruction and waits for its completion pulse.
  task ex(input [5:0] o, input i, input [1:0] x, input [16:0] a, input dr, input [2:0] s);
    begin
      @(posedge clk_sys_in);
      start_in <= 1'b1;
      op_in <= o;
      indirect_in <= i;
      index_sel_in <= x;
      addr_in <= a;
      dir_in <= dr;
      sub_op_in <= s;
      @(posedge clk_sys_in);
      start_in <= 1'b0;
      while (done_out !== 1'b1)
        @(posedge clk_sys_in);
    end
  endtask

  // Main sequence of instruction tests.
  initial begin
    mm_u.mem[15'h105] = 24'habcdef;
    mm_u.mem[15'h200] = 24'h000300;
    mm_u.mem[15'h300] = 24'h123456;
    mm_u.mem[15'h400] = 24'h111111;
    mm_u.mem[15'h401] = 24'h222222;
    mm_u.mem[15'h500] = 24'hffffff;
    mm_u.mem[15'h600] = 24'hffffff;
    mm_u.mem[15'h601] = 24'hffffff;
    mm_u.mem[15'h602] = 24'hffffff;
    mm_u.mem[15'h603] = 24'hffffff;
    mm_u.mem[15'h604] = 24'hfedcba;
    mm_u.mem[15'h605] = 24'h018604;
    repeat (4) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    rchk("ctrl", `LSTU_REG_CTRL, 32'h1);
    apb(1'b0, 8'h1c, 32'h0);
    chk("slverr", {31'h0, err}, 32'h1);
    apb(1'b1, `LSTU_REG_IDX1, 32'h5);
    ex(`LSTU_OP_LD_ACC, 1'b0, 2'h1, 17'h100, 1'b0, 3'h0);
    rchk("lda", `LSTU_REG_ACC, 32'habcdef);
    ex(`LSTU_OP_LD_EXT, 1'b1, 2'h0, 17'h200, 1'b0, 3'h0);
    rchk("ldq", `LSTU_REG_EXT, 32'h123456);
    ex(`LSTU_OP_LD_INV, 1'b0, 2'h0, 17'h300, 1'b0, 3'h0);
    rchk("lca", `LSTU_REG_ACC, 32'hedcba9);
    lat <= 2'h3;
    ex(`LSTU_OP_LD_DBL, 1'b0, 2'h0, 17'h400, 1'b0, 3'h0);
    rchk("load_double_word_a", `LSTU_REG_ACC, 32'h111111);
    rchk("load_double_word_q", `LSTU_REG_EXT, 32'h222222);
    ex(`LSTU_OP_LD_DINV, 1'b0, 2'h0, 17'h400, 1'b0, 3'h0);
    rchk("load_double_inv_a", `LSTU_REG_ACC, 32'heeeeee);
    rchk("load_double_inv_q", `LSTU_REG_EXT, 32'hdddddd);
    apb(1'b1, `LSTU_REG_EXT, 32'h0f0f0f);
    ex(`LSTU_OP_LD_MASK, 1'b0, 2'h1, 17'h100, 1'b0, 3'h0);
    rchk("ldl", `LSTU_REG_ACC, 32'h0b0d0f);
    ex(`LSTU_OP_LD_ACH, 1'b1, 2'h1, 17'h410, 1'b0, 3'h0);
    rchk("load_acc_char", `LSTU_REG_ACC, 32'h3c);
    apb(1'b1, `LSTU_REG_IDX2, 32'h3);
    ex(`LSTU_OP_LD_ECH, 1'b0, 2'h1, 17'h412, 1'b0, 3'h0);
    rchk("load_ext_char", `LSTU_REG_EXT, 32'h3c);
    apb(1'b1, `LSTU_REG_ACC, 32'h5555ea);
    ex(`LSTU_OP_ST_ACH, 1'b1, 2'h1, 17'h13ff, 1'b0, 3'h0);
    chk("store_acc_char", mm_u.mem[15'h500], 32'hfffabf);
    ex(`LSTU_OP_ST_ECH, 1'b0, 2'h1, 17'h13fb, 1'b0, 3'h0);
    chk("store_ext_char", mm_u.mem[15'h500], 32'hf3fabf);
    rchk("store_ext_char_q", `LSTU_REG_EXT, 32'h3c);
    ex(`LSTU_OP_ST_WPTR, 1'b0, 2'h0, 17'h600, 1'b0, 3'h0);
    chk("swa", mm_u.mem[15'h600], 32'hffd5ea);
    ex(`LSTU_OP_ST_CPTR, 1'b0, 2'h0, 17'h601, 1'b0, 3'h0);
    chk("store_char_pointer", mm_u.mem[15'h601], 32'hff55ea);
    ex(`LSTU_OP_ST_DBL, 1'b0, 2'h1, 17'h6fb, 1'b0, 3'h0);
    chk("store_double_word_a", mm_u.mem[15'h700], 32'h5555ea);
    chk("store_double_word_q", mm_u.mem[15'h701], 32'h3c);
    rchk("sta_keep", `LSTU_REG_ACC, 32'h5555ea);
    ex(`LSTU_OP_ST_IDX, 1'b0, 2'h0, 17'h602, 1'b0, 3'h0);
    chk("sti0", mm_u.mem[15'h602], 32'hff8000);
    ex(`LSTU_OP_ST_IDX, 1'b0, 2'h1, 17'h603, 1'b0, 3'h0);
    chk("sti1", mm_u.mem[15'h603], 32'hff8005);
    apb(1'b1, `LSTU_REG_IDX3, 32'h7);
    ex(`LSTU_OP_LD_IDX, 1'b0, 2'h3, 17'h604, 1'b0, 3'h0);
    rchk("ldi", `LSTU_REG_IDX3, 32'h5cba);
    ex(`LSTU_OP_LD_IDX, 1'b1, 2'h2, 17'h605, 1'b0, 3'h0);
    rchk("ldi_ind", `LSTU_REG_IDX2, 32'h5cba);
    ex(`LSTU_OP_XFER, 1'b0, 2'h2, 17'h0, 1'b1, `LSTU_SUB_IDX_ACC);
    rchk("tai", `LSTU_REG_IDX2, 32'h55ea);
    ex(`LSTU_OP_XFER, 1'b0, 2'h3, 17'h0, 1'b0, `LSTU_SUB_IDX_ACC);
    rchk("tia", `LSTU_REG_ACC, 32'h5cba);
    ex(`LSTU_OP_XFER, 1'b0, 2'h0, 17'h3f, 1'b1, `LSTU_SUB_FL_ACC);
    ex(`LSTU_OP_XFER, 1'b0, 2'h0, 17'h3f, 1'b0, `LSTU_SUB_FL_EXT);
    rchk("tmq", `LSTU_REG_EXT, 32'h5cba);
    ex(`LSTU_OP_XFER, 1'b0, 2'h2, 17'h3e, 1'b1, `LSTU_SUB_FL_IDX);
    ex(`LSTU_OP_XFER, 1'b0, 2'h1, 17'h3e, 1'b0, `LSTU_SUB_FL_IDX);
    rchk("tmi", `LSTU_REG_IDX1, 32'h55ea);
    ex(`LSTU_OP_XFER, 1'b0, 2'h0, 17'h3e, 1'b0, `LSTU_SUB_FL_ACC);
    rchk("tma", `LSTU_REG_ACC, 32'h55ea);
    ex(`LSTU_OP_XFER, 1'b0, 2'h0, 17'h3f, 1'b0, `LSTU_SUB_FL_ACC);
    rchk("tma_back", `LSTU_REG_ACC, 32'h5cba);
    apb(1'b1, `LSTU_REG_EXT, 32'hffb000);
    ex(`LSTU_OP_XFER, 1'b0, 2'h0, 17'h0, 1'b0, `LSTU_SUB_SUM_AE);
    rchk("aqa", `LSTU_REG_ACC, 32'h000cba);
    apb(1'b1, `LSTU_REG_IDX1, 32'h7fff);
    ex(`LSTU_OP_XFER, 1'b0, 2'h1, 17'h0, 1'b0, `LSTU_SUB_SUM_AI);
    rchk("aia", `LSTU_REG_ACC, 32'h000cb9);
    ex(`LSTU_OP_XFER, 1'b0, 2'h1, 17'h0, 1'b0, `LSTU_SUB_SUM_IA);
    rchk("iai", `LSTU_REG_IDX1, 32'h0cb8);
    report_and_stop;
  end
endmodule // tb_load_store_transfer_unit
